//--- src/mclk_rx_ctrl_regs.svh
/*
 * Offsets, field positions, reset values and zero-run thresholds of the
 * master clock and receive control register.
 * Assumes inclusion by bare name from design files.
 */
`ifndef MCLK_RX_CTRL_REGS_SVH
`define MCLK_RX_CTRL_REGS_SVH

// Register address on the host access port (5-bit address)
`define MCRC_ADDR          5'h11
// Field positions inside the 8-bit register
`define MCRC_SRC_HI_BIT    5
`define MCRC_SRC_LO_BIT    4
`define MCRC_RATE_BIT      3
`define MCRC_MUTE_BIT      2
`define MCRC_LONG_LOSS_BIT 1
`define MCRC_TEST_BIT      0
// Reset value of the six control bits
`define MCRC_RESET         6'h00
// Consecutive zeros before signal loss is declared
`define LOS_EXT_ZEROS      4096
`define LOS_T1_ZEROS       175
`define LOS_E1_ZEROS       32

`endif

//--- src/mclk_rx_ctrl_pkg.sv
/*
 * Types shared by the master clock and receive control logic.
 * Assumes the constants header is included where numbers are needed.
 */
package mclk_rx_ctrl_pkg;

    // Synthesized line rate, E1 encodes as 0
    typedef enum logic {
        RATE_E1,
        RATE_T1
    } line_rate_type;

    // Six control bits, D5 down to D0
    typedef struct packed {
        logic          synth_source_sel_hi;
        logic          synth_source_sel_lo;
        line_rate_type synth_rate_choice;
        logic          receive_output_silence;
        logic          long_signal_loss_count;
        logic          board_test_tristate;
    } ctrl_fields_type;

    // One received bit pair
    typedef struct packed {
        logic pos;
        logic neg;
    } rx_bit_type;

endpackage

//--- src/signal_loss_counter.sv
/*
 * Counts consecutive zero bits at the receive input and raises the
 * signal loss flag once the selected threshold is reached.
 * Assumes bit_en_i pulses once per received bit, synchronous to clock.
 */
`timescale 1ns/1ps
`include "mclk_rx_ctrl_regs.svh"
module signal_loss_counter
#(
    parameter int CNT_W = 13
)
(
    input  wire logic             ref_clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             bit_en_i,
    input  wire logic             zero_i,
    input  wire logic [CNT_W-1:0] thr_i,
    output logic                  los_o
);

    // Threshold must fit the counter; refused at elaboration
    if (CNT_W < $clog2(`LOS_EXT_ZEROS + 1))
    begin : g_cnt_w_check
        $error("signal_loss_counter: CNT_W too small");
    end

    logic [CNT_W-1:0] zero_cnt_reg;  // Current run of zeros

    ////////////////////////////////////////////////////////////////////
    // Zero run counter, saturating at the threshold
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            zero_cnt_reg <= '0;
        else if (bit_en_i && !zero_i)
            zero_cnt_reg <= '0;                    // see RULE10
        else if (bit_en_i && zero_cnt_reg < thr_i)
            zero_cnt_reg <= zero_cnt_reg + 1'b1;
    end

    // Flag follows the count against the live threshold
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            los_o <= 1'b0;
        else if (bit_en_i && !zero_i)
            los_o <= 1'b0;                         // see RULE10
        else if (bit_en_i && zero_cnt_reg + 1'b1 >= thr_i)
            los_o <= 1'b1;                         // see RULE6 RULE7
    end

    ////////////////////////////////////////////////////////////////////
    // A one always ends the run
    AST_ONE_CLEARS: assert property (  // see RULE10
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        bit_en_i && !zero_i |=> !los_o && zero_cnt_reg == '0)
        else $error("zero run not cleared by a one");

    // Reaching the threshold declares loss next cycle
    AST_THRESH_HIT: assert property (  // see RULE6
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        bit_en_i && zero_i && zero_cnt_reg + 1'b1 == thr_i
        |=> los_o)
        else $error("loss not declared at threshold");

    // Below threshold the flag must not rise
    AST_NO_EARLY: assert property (  // see RULE7
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        !los_o && zero_cnt_reg + 2 < {1'b0, thr_i}
        |=> !los_o)
        else $error("loss declared early");

endmodule // signal_loss_counter

//--- src/master_clock_and_receive_control_reg.sv
/*
 * Master clock and receive control register: synthesizer select and
 * rate, receive output mute, extended signal loss and board test
 * tristate, with the receive output stage these bits steer.
 * Assumes the serial host interface decodes frames into the one-cycle
 * host_wr_i / host_rd_i strobes below, and that receive inputs and
 * the hardware mode strap are synchronous to ref_clk_i.
 */
//
// Contract
// RULE1 - Hardware mode: synthesizer follows pins, not bits
// RULE2 - D5, D4 hold synthesizer source select
// RULE3 - D3: 0 gives E1, 1 gives T1/J1
// RULE4 - D2 set forces both receive data low
// RULE5 - Receive clock keeps toggling while muted
// RULE6 - D1 set: loss after 4096 zeros
// RULE7 - D1 clear: 175 zeros T1, 32 E1
// RULE8 - D0 set tristates every output pin
// RULE9 - Test pin low acts same as D0
// RULE10 - Zero count clears on one, live threshold
// RULE11 - Six bits read back, reset to zero
`timescale 1ns/1ps
`include "mclk_rx_ctrl_regs.svh"
module master_clock_and_receive_control_reg
#(
    parameter int LOS_CNT_W = 13
)
(
    input  wire logic                      ref_clk_i,
    input  wire logic                      sys_rst_i,
    // Host register access
    input  wire logic                      host_wr_i,
    input  wire logic                      host_rd_i,
    input  wire logic [4:0]                host_addr_i,
    input  wire logic [7:0]                host_wdata_i,
    output logic      [7:0]                host_rdata_o,
    output logic                           host_rvalid_o,
    // Hardware mode strap and pins
    input  wire logic                      hw_mode_i,
    input  wire logic [1:0]                hw_synth_sel_i,
    input  wire mclk_rx_ctrl_pkg::line_rate_type hw_synth_rate_i,
    input  wire logic                      test_pin_n_i,
    // Synthesizer control
    output logic [1:0]                     synth_source_sel_o,
    output mclk_rx_ctrl_pkg::line_rate_type synth_rate_choice_o,
    // Receive side
    input  wire logic                      recv_clk_i,
    input  wire logic                      recv_bit_en_i,
    input  wire mclk_rx_ctrl_pkg::rx_bit_type recv_bit_i,
    output logic                           recv_positive_data_out_o,
    output logic                           recv_negative_violation_out_o,
    output logic                           recv_clock_out_o,
    output logic                           receive_signal_loss_flag_o,
    output logic                           pins_oe_n_o
);

    import mclk_rx_ctrl_pkg::*;

    // Counter must hold the longest zero run; refused at elaboration
    if (LOS_CNT_W < $clog2(`LOS_EXT_ZEROS + 1))
    begin : g_los_cnt_w_check
        $error("LOS_CNT_W too small for the extended threshold");
    end

    ////////////////////////////////////////////////////////////////////
    // Declarations
    ctrl_fields_type       ctrl_reg;       // Host written control bits
    logic [LOS_CNT_W-1:0]  los_thr;        // Selected zero threshold
    line_rate_type         rate_eff;       // Rate seen by the LOS logic
    logic                  addr_hit;       // Access targets this register
    logic                  test_req;       // Either test source asserted
    logic                  los_raw;        // Flag from the zero counter

    ////////////////////////////////////////////////////////////////////
    // Zero threshold for the current mode and rate
    function automatic logic [LOS_CNT_W-1:0] los_threshold(
        input logic          ext,
        input line_rate_type rate
    );
        if (ext)
            return LOS_CNT_W'(`LOS_EXT_ZEROS);
        else if (rate == RATE_T1)
            return LOS_CNT_W'(`LOS_T1_ZEROS);
        else
            return LOS_CNT_W'(`LOS_E1_ZEROS);
    endfunction

    // Address decode shared by read and write
    assign addr_hit = (host_addr_i == `MCRC_ADDR);

    ////////////////////////////////////////////////////////////////////
    // Control register write; other addresses belong elsewhere
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            ctrl_reg <= ctrl_fields_type'(`MCRC_RESET);   // see RULE11
        else if (host_wr_i && addr_hit)
        begin
            // Bits D7, D6 are not stored here
            ctrl_reg <= ctrl_fields_type'(host_wdata_i[5:0]); // see RULE2
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            host_rdata_o  <= 8'h00;
            host_rvalid_o <= 1'b0;
        end
        else
        begin
            host_rvalid_o <= host_rd_i;
            if (host_rd_i && addr_hit)
                host_rdata_o <= {2'b00, ctrl_reg};        // see RULE11
            else if (host_rd_i)
                host_rdata_o <= 8'h00;     // Unmapped here reads zero
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Synthesizer control; the strap picks pins or register bits
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            synth_source_sel_o  <= 2'h0;
            synth_rate_choice_o <= RATE_E1;
        end
        else if (hw_mode_i)
        begin
            // Register bits ignored while strapped
            synth_source_sel_o  <= hw_synth_sel_i;        // see RULE1
            synth_rate_choice_o <= hw_synth_rate_i;       // see RULE1
        end
        else
        begin
            synth_source_sel_o  <= {ctrl_reg.synth_source_sel_hi,
                                    ctrl_reg.synth_source_sel_lo};
            synth_rate_choice_o <= ctrl_reg.synth_rate_choice; // see RULE3
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Receive data outputs; mute forces both low
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            recv_positive_data_out_o      <= 1'b0;
            recv_negative_violation_out_o <= 1'b0;
        end
        else if (ctrl_reg.receive_output_silence)
        begin
            recv_positive_data_out_o      <= 1'b0;        // see RULE4
            recv_negative_violation_out_o <= 1'b0;        // see RULE4
        end
        else
        begin
            recv_positive_data_out_o      <= recv_bit_i.pos;
            recv_negative_violation_out_o <= recv_bit_i.neg;
        end
    end

    // Receive clock retimed with the data, never gated by mute
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            recv_clock_out_o <= 1'b0;
        else
            recv_clock_out_o <= recv_clk_i;               // see RULE5
    end

    ////////////////////////////////////////////////////////////////////
    // Signal loss detection; rate follows the synthesizer output so
    // the threshold matches the line actually being received
    assign rate_eff = synth_rate_choice_o;
    assign los_thr  = los_threshold(ctrl_reg.long_signal_loss_count,
                                    rate_eff);            // see RULE6 RULE7

    signal_loss_counter
    #(
        .CNT_W     (LOS_CNT_W)
    )
    u_los_cnt
    (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .bit_en_i  (recv_bit_en_i),
        .zero_i    (!recv_bit_i.pos && !recv_bit_i.neg),
        .thr_i     (los_thr),                             // see RULE10
        .los_o     (los_raw)
    );

    assign receive_signal_loss_flag_o = los_raw;

    ////////////////////////////////////////////////////////////////////
    // Board test: register bit or grounded test pin, same effect
    assign test_req = ctrl_reg.board_test_tristate
                      || !test_pin_n_i;                   // see RULE9

    // Output enable, low while driving; one flop so all pins float
    // together rather than glitching on a decode path
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            pins_oe_n_o <= 1'b0;
        else
            pins_oe_n_o <= test_req;                      // see RULE8
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    AST_HW_PINS: assert property (  // see RULE1
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        hw_mode_i |=> synth_source_sel_o == $past(hw_synth_sel_i)
                      && synth_rate_choice_o == $past(hw_synth_rate_i))
        else $error("strapped synthesizer not following pins");

    AST_READBACK: assert property (  // see RULE2
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        host_wr_i && addr_hit ##1 host_rd_i && addr_hit
        |=> host_rvalid_o
            && host_rdata_o == {2'b00, $past(host_wdata_i[5:0], 2)})
        else $error("control bits do not read back");

    AST_RATE: assert property (  // see RULE3
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        !hw_mode_i && !(host_wr_i && addr_hit)
        ##1 !hw_mode_i
        |=> synth_rate_choice_o == $past(ctrl_reg.synth_rate_choice, 2))
        else $error("rate bit not steering synthesizer");

    AST_MUTE: assert property (  // see RULE4
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        ctrl_reg.receive_output_silence
        |=> !recv_positive_data_out_o && !recv_negative_violation_out_o)
        else $error("muted receive data not low");

    AST_CLK_UNMUTED: assert property (  // see RULE5
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        ctrl_reg.receive_output_silence && recv_clk_i
        |=> recv_clock_out_o)
        else $error("receive clock suppressed by mute");

    AST_EXT_THR: assert property (  // see RULE6
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        ctrl_reg.long_signal_loss_count |-> los_thr == 4096)
        else $error("extended threshold not 4096");

    AST_NORM_THR: assert property (  // see RULE7
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        !ctrl_reg.long_signal_loss_count
        |-> los_thr == (rate_eff == RATE_T1 ? 175 : 32))
        else $error("normal threshold wrong");

    AST_TEST_TRI: assert property (  // see RULE8
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        ctrl_reg.board_test_tristate |=> pins_oe_n_o)
        else $error("test bit did not float outputs");

    AST_TEST_PIN: assert property (  // see RULE9
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        !test_pin_n_i && !ctrl_reg.board_test_tristate
        |=> pins_oe_n_o ##1 (pins_oe_n_o == $past(test_req)))
        else $error("test pin not equivalent to test bit");

endmodule // master_clock_and_receive_control_reg

//--- verification/host_cpu_model.sv
/*
 * Host processor model: register writes and reads as one-cycle strobes.
 * Assumes one bench process calls its tasks.
 */
`timescale 1ns/1ps
module host_cpu_model
(
    input  wire logic       ref_clk_i,
    input  wire logic [7:0] host_rdata_i,
    input  wire logic       host_rvalid_i,
    output logic            host_wr_o,
    output logic            host_rd_o,
    output logic [4:0]      host_addr_o,
    output logic [7:0]      host_wdata_o
);
    ////////////////////////////////////////////////////////////////////
    // Bus idle at time zero
    initial
    begin
        host_wr_o    = 1'b0;
        host_rd_o    = 1'b0;
        host_addr_o  = 5'h00;
        host_wdata_o = 8'h00;
    end

    // Released data is inverted so stale values never pass as valid
    task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        host_wr_o    <= 1'b1;
        host_addr_o  <= a;
        host_wdata_o <= d;
        @(posedge ref_clk_i);
        host_wr_o    <= 1'b0;
        host_wdata_o <= ~d;
    endtask

    // Bounded wait for the answer; ok stays low on a hang
    task automatic read_reg(input logic [4:0] a, output logic [7:0] d,
                            output logic ok);
        int n;
        ok = 1'b0;
        d  = 8'h00;
        @(posedge ref_clk_i);
        host_rd_o   <= 1'b1;
        host_addr_o <= a;
        @(posedge ref_clk_i);
        host_rd_o   <= 1'b0;
        for (n = 0; n < 4 && !ok; n++)
        begin
            #1;
            ok = (host_rvalid_i === 1'b1);
            d  = host_rdata_i;
            if (!ok)
                @(posedge ref_clk_i);
        end
    endtask

    // Write, then read on the very next edge, back to back
    task automatic write_read(input logic [4:0] a, input logic [7:0] d,
                              output logic [7:0] q, output logic ok);
        int n;
        ok = 1'b0;
        q  = 8'h00;
        @(posedge ref_clk_i);
        host_wr_o    <= 1'b1;
        host_addr_o  <= a;
        host_wdata_o <= d;
        @(posedge ref_clk_i);
        host_wr_o    <= 1'b0;
        host_wdata_o <= ~d;
        host_rd_o    <= 1'b1;
        @(posedge ref_clk_i);
        host_rd_o    <= 1'b0;
        for (n = 0; n < 4 && !ok; n++)
        begin
            #1;
            ok = (host_rvalid_i === 1'b1);
            q  = host_rdata_i;
            if (!ok)
                @(posedge ref_clk_i);
        end
    endtask
endmodule // host_cpu_model

//--- verification/master_clock_and_receive_control_reg_tb.sv
/*
 * Self-checking bench for the master clock and receive control register.
 * Assumes the design, package and constants header are compiled first.
 */
`timescale 1ns/1ps
`include "mclk_rx_ctrl_regs.svh"
module master_clock_and_receive_control_reg_tb;
    import mclk_rx_ctrl_pkg::*;
    logic          clk, rst, wr, rd, rvalid, hw_mode, test_pin_n;
    logic          rclk, ben, pos_o, neg_o, rclk_o, loss, oe_n;
    logic [4:0]    addr;
    logic [7:0]    wdata, rdata;
    logic [1:0]    hw_sel, sel;
    line_rate_type hw_rate, rate;
    rx_bit_type    rbit;
    int            fails = 0;
    int            n_tests = 0;

    ////////////////////////////////////////////////////////////////////
    // Clock, 5 ns period; receive clock toggles every cycle
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) rclk <= rst ? 1'b0 : ~rclk;

    master_clock_and_receive_control_reg u_master_clock_and_receive_control_reg
    (
        .ref_clk_i(clk), .sys_rst_i(rst), .host_wr_i(wr), .host_rd_i(rd),
        .host_addr_i(addr), .host_wdata_i(wdata), .host_rdata_o(rdata),
        .host_rvalid_o(rvalid), .hw_mode_i(hw_mode),
        .hw_synth_sel_i(hw_sel), .hw_synth_rate_i(hw_rate),
        .test_pin_n_i(test_pin_n), .synth_source_sel_o(sel),
        .synth_rate_choice_o(rate), .recv_clk_i(rclk),
        .recv_bit_en_i(ben), .recv_bit_i(rbit),
        .recv_positive_data_out_o(pos_o),
        .recv_negative_violation_out_o(neg_o), .recv_clock_out_o(rclk_o),
        .receive_signal_loss_flag_o(loss), .pins_oe_n_o(oe_n)
    );

    host_cpu_model u_host_cpu_model
    (
        .ref_clk_i(clk), .host_rdata_i(rdata), .host_rvalid_i(rvalid),
        .host_wr_o(wr), .host_rd_o(rd), .host_addr_o(addr),
        .host_wdata_o(wdata)
    );

    ////////////////////////////////////////////////////////////////////
    // Verdict, the only exit
    task automatic end_of_test();
        if (fails == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Four-state compare
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t %s got %h want %h", $time, what, seen, exp);
        end
    endtask

    // Settle n edges, then sample past the edge
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        u_host_cpu_model.write_reg(a, d);
    endtask

    // Read with a hang counted as a mismatch
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        u_host_cpu_model.read_reg(a, d, ok);
        if (!ok)
        begin
            fails++;
            $display("[ERR] %0t read timed out", $time);
            end_of_test();
        end
        else
            chk(d, exp, "read data");
    endtask

    // Back-to-back write and read, hang counted as a mismatch
    task automatic wr_rd_chk(input logic [7:0] d, input logic [7:0] exp);
        logic [7:0] q;
        logic       ok;
        u_host_cpu_model.write_read(`MCRC_ADDR, d, q, ok);
        if (!ok)
        begin
            fails++;
            $display("[ERR] %0t write-read timed out", $time);
            end_of_test();
        end
        else
            chk(q, exp, "write then read");
    endtask

    // Hold bit enable over n bits of one value
    task automatic send_bits(input int n, input logic p, input logic q);
        @(posedge clk);
        ben  <= 1'b1;
        rbit <= rx_bit_type'({p, q});
        repeat (n) @(posedge clk);
        ben  <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic check_reset();
        wait_cyc(1);
        chk({sel, 6'(rate)}, 8'h00, "reset synth");
        chk({oe_n, 7'(loss)}, 8'h00, "reset oe");
        rd_chk(`MCRC_ADDR, 8'h00);
    endtask

    // Upper bits dropped, other addresses refused
    task automatic check_readback();
        wr_reg(`MCRC_ADDR, 8'hFF);
        rd_chk(`MCRC_ADDR, 8'h3F);
        chk({sel, 6'(rate)}, 8'hC1, "sel 11 T1");
        wr_reg(5'h12, 8'h00);
        rd_chk(`MCRC_ADDR, 8'h3F);
        rd_chk(5'h12, 8'h00);
        wr_rd_chk(8'hE6, 8'h26);
        wr_reg(`MCRC_ADDR, 8'h10);
        wait_cyc(2);
        chk({sel, 6'(rate)}, 8'h40, "sel 01 E1");
    endtask

    // Pins steer the synthesizer, register keeps its value
    task automatic check_hw_mode();
        wr_reg(`MCRC_ADDR, 8'h08);
        @(posedge clk);
        hw_mode <= 1'b1;
        hw_sel  <= 2'b10;
        wait_cyc(3);
        chk({sel, 6'(rate)}, 8'h80, "hw pins");
        rd_chk(`MCRC_ADDR, 8'h08);
        @(posedge clk);
        hw_mode <= 1'b0;
        wait_cyc(3);
        chk({sel, 6'(rate)}, 8'h01, "bits back");
    endtask

    task automatic check_mute();
        @(posedge clk);
        rbit <= rx_bit_type'(2'b11);
        wr_reg(`MCRC_ADDR, 8'h00);
        wait_cyc(2);
        chk({pos_o, 7'(neg_o)}, 8'h81, "data pass");
        wr_reg(`MCRC_ADDR, 8'h04);
        wait_cyc(2);
        chk({pos_o, 7'(neg_o)}, 8'h00, "data muted");
        chk(8'(rclk_o), 8'(!rclk), "clock live");
        wait_cyc(1);
        chk(8'(rclk_o), 8'(!rclk), "clock live");
        wr_reg(`MCRC_ADDR, 8'h00);
    endtask

    task automatic check_tristate();
        wr_reg(`MCRC_ADDR, 8'h01);
        wait_cyc(2);
        chk(8'(oe_n), 8'h01, "test bit");
        wr_reg(`MCRC_ADDR, 8'h00);
        wait_cyc(2);
        chk(8'(oe_n), 8'h00, "driven");
        @(posedge clk);
        test_pin_n <= 1'b0;
        wait_cyc(2);
        chk(8'(oe_n), 8'h01, "test pin");
        @(posedge clk);
        test_pin_n <= 1'b1;
        wait_cyc(2);
        chk(8'(oe_n), 8'h00, "pin off");
    endtask

    // A one mid-run restarts the count; flag only at the threshold
    task automatic los_run(input logic [7:0] w, input int thr);
        wr_reg(`MCRC_ADDR, w);
        send_bits(1, 1'b1, 1'b0);
        send_bits(thr - 1, 1'b0, 1'b0);
        send_bits(1, 1'b0, 1'b1);
        send_bits(thr - 1, 1'b0, 1'b0);
        wait_cyc(2);
        chk(8'(loss), 8'h00, "early loss");
        send_bits(1, 1'b0, 1'b0);
        wait_cyc(2);
        chk(8'(loss), 8'h01, "loss at count");
        send_bits(1, 1'b1, 1'b0);
        wait_cyc(2);
        chk(8'(loss), 8'h00, "loss cleared");
    endtask

    task automatic check_loss();
        los_run(8'h00, `LOS_E1_ZEROS);
        los_run(8'h08, `LOS_T1_ZEROS);
        los_run(8'h02, `LOS_EXT_ZEROS);
        los_run(8'h0A, `LOS_EXT_ZEROS);
    endtask

    // Reset mid-run clears every control bit and the synthesizer, loss and output enable outputs
    task automatic check_mid_reset();
        wr_reg(`MCRC_ADDR, 8'h3F);
        wait_cyc(2);
        chk(8'(oe_n), 8'h01, "before reset");
        @(posedge clk);
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        check_reset();
    endtask

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        rst        <= 1'b1;
        rclk       <= 1'b0;
        ben        <= 1'b0;
        rbit       <= rx_bit_type'(2'b00);
        hw_mode    <= 1'b0;
        hw_sel     <= 2'b00;
        hw_rate    <= RATE_E1;
        test_pin_n <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        check_reset();
        check_readback();
        check_hw_mode();
        check_mute();
        check_tristate();
        check_loss();
        check_mid_reset();
        end_of_test();
    end
endmodule // master_clock_and_receive_control_reg_tb
